// [gpio_bc_pkg.sv]
// Constants shared by the port B / port C data register block.
// Assumes a 16-bit register port with byte-free word access.
package gpio_bc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PB_W   = 14;
  localparam int PC_W   = 21;
  localparam int PCH_W  = 5;
  localparam int PCL_W  = 16;
  localparam int SYNC_STAGES = 3;

  localparam logic [ADDR_W-1:0] OFS_PB_DATA   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PC_DATA_H = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PC_DATA_L = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PB_DIR    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PB_FUNC   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PC_DIR_H  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PC_DIR_L  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PC_FUNC_H = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PC_FUNC_L = 8'h20;

  localparam int PCH_LSB = 16;

  localparam logic [PB_W-1:0]   RST_PB   = 14'h0000;
  localparam logic [PC_W-1:0]   RST_PC   = 21'h000000;
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
endpackage : gpio_bc_pkg

// [pin_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous pin levels.
// Assumes pins are unrelated to REF_CLK; the level output is registered.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // Block clock
  input  wire logic             nrst,   // Async reset, active low
  input  wire logic [WIDTH-1:0] din,    // Raw pin levels
  output logic      [WIDTH-1:0] level   // Filtered pin levels
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_nxt;

  // Only stages two and three are compared; stage one may be metastable
  always_comb begin
    level_nxt = (s2_r & s3_r) | (level & (s2_r ^ s3_r));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      level <= '0;
    end else begin
      s1_r  <= din;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      level <= level_nxt;
    end
  end
endmodule : pin_sync

// [port_data_bc.sv]
// Data registers for a 14-pin port B and a 21-pin port C, with direction
// and function-select registers, reached over a plain strobe register port.
// Assumes pins are asynchronous to REF_CLK and an external pad resolves
// each pin from its drive value and active-low output enable.
//
// Behaviour
// [R01] The port B data register is a 16-bit read/write register holding port B data.
// [R02] Port B data bits 13..0 map one-to-one onto port B pins 13..0.
// [R03] A port B general-output pin drives the value written to its data bit.
// [R04] Reading a port B general-output bit returns the stored value, not the pin.
// [R05] Reading a port B general-input bit returns the live pin level.
// [R06] Writing a port B general-input bit updates the register but not the pin.
// [R07] A port B pin on another function reads the register and is never driven.
// [R08] Port B bits 15..14 and port C high bits 15..5 always read as zero.
// [R09] Software writes zero to every reserved bit position.
// [R10] Port C data is held in a high and a low 16-bit read/write register.
// [R11] Port C data bits 20..0 map one-to-one onto port C pins 20..0.
// [R12] Port C pins 20..16 sit in high bits 4..0, pins 15..0 in low bits 15..0.
// [R13] A port C general-output pin drives the value written in either register.
// [R14] Reading a port C general-output bit returns the stored value.
// [R15] Reading a port C general-input bit returns the live pin level.
// [R16] Writing a port C general-input bit updates the register but not the pin.
// [R17] A port C pin on another function reads the register and is never driven.
`timescale 1ns/100ps
module port_data_bc
  import gpio_bc_pkg::*;
(
  input  wire logic                           REF_CLK,  // 25 MHz clock
  input  wire logic                           NRST,     // Async reset, active low
  input  wire logic [gpio_bc_pkg::ADDR_W-1:0] ADDR,     // Register address
  input  wire logic [gpio_bc_pkg::DATA_W-1:0] WDATA,    // Write data
  input  wire logic                           WR,       // Write strobe
  input  wire logic                           RD,       // Read strobe
  output logic      [gpio_bc_pkg::DATA_W-1:0] RDATA,    // Read data, cycle after RD
  input  wire logic [gpio_bc_pkg::PB_W-1:0]   PB_DIN,   // Port B pin levels
  output logic      [gpio_bc_pkg::PB_W-1:0]   PB_DOUT,  // Port B drive values
  output logic      [gpio_bc_pkg::PB_W-1:0]   PB_OE_N,  // Port B enable, low drives
  input  wire logic [gpio_bc_pkg::PC_W-1:0]   PC_DIN,   // Port C pin levels
  output logic      [gpio_bc_pkg::PC_W-1:0]   PC_DOUT,  // Port C drive values
  output logic      [gpio_bc_pkg::PC_W-1:0]   PC_OE_N   // Port C enable, low drives
);
  import gpio_bc_pkg::*;

  logic [PB_W-1:0]   pb_data_r, pb_data_nxt;
  logic [PB_W-1:0]   pb_dir_r, pb_dir_nxt;
  logic [PB_W-1:0]   pb_func_r, pb_func_nxt;
  logic [PC_W-1:0]   pc_data_r, pc_data_nxt;
  logic [PC_W-1:0]   pc_dir_r, pc_dir_nxt;
  logic [PC_W-1:0]   pc_func_r, pc_func_nxt;
  logic [PB_W-1:0]   pb_oe_n_r, pb_oe_n_nxt;
  logic [PC_W-1:0]   pc_oe_n_r, pc_oe_n_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [PB_W-1:0]   pb_pin;
  logic [PC_W-1:0]   pc_pin;
  logic [PB_W-1:0]   pb_view;
  logic [PC_W-1:0]   pc_view;
  logic [PB_W-1:0]   pb_regsel;
  logic [PC_W-1:0]   pc_regsel;

  pin_sync #(.WIDTH(PB_W)) u_pb_sync (
    .clk   (REF_CLK),
    .nrst  (NRST),
    .din   (PB_DIN),
    .level (pb_pin)
  );

  pin_sync #(.WIDTH(PC_W)) u_pc_sync (
    .clk   (REF_CLK),
    .nrst  (NRST),
    .din   (PC_DIN),
    .level (pc_pin)
  );

  // Register writes; reserved positions are simply not stored
  always_comb begin
    pb_data_nxt = pb_data_r;
    pb_dir_nxt  = pb_dir_r;
    pb_func_nxt = pb_func_r;
    pc_data_nxt = pc_data_r;
    pc_dir_nxt  = pc_dir_r;
    pc_func_nxt = pc_func_r;
    if (WR) begin
      unique case (ADDR)
        OFS_PB_DATA:   pb_data_nxt = WDATA[PB_W-1:0];                  // see [R01] [R02] [R06]
        OFS_PC_DATA_H: pc_data_nxt[PC_W-1:PCH_LSB] = WDATA[PCH_W-1:0]; // see [R10] [R12] [R16]
        OFS_PC_DATA_L: pc_data_nxt[PCL_W-1:0] = WDATA;                 // see [R10] [R11] [R12]
        OFS_PB_DIR:    pb_dir_nxt = WDATA[PB_W-1:0];
        OFS_PB_FUNC:   pb_func_nxt = WDATA[PB_W-1:0];
        OFS_PC_DIR_H:  pc_dir_nxt[PC_W-1:PCH_LSB] = WDATA[PCH_W-1:0];
        OFS_PC_DIR_L:  pc_dir_nxt[PCL_W-1:0] = WDATA;
        OFS_PC_FUNC_H: pc_func_nxt[PC_W-1:PCH_LSB] = WDATA[PCH_W-1:0];
        OFS_PC_FUNC_L: pc_func_nxt[PCL_W-1:0] = WDATA;
        default: ;
      endcase
    end
  end

  // Only a general output drives; input or other-function pins float here
  always_comb begin
    pb_oe_n_nxt = ~(pb_dir_nxt & ~pb_func_nxt); // see [R03] [R06] [R07]
    pc_oe_n_nxt = ~(pc_dir_nxt & ~pc_func_nxt); // see [R13] [R16] [R17]
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pb_data_r <= RST_PB;
      pb_dir_r  <= RST_PB;
      pb_func_r <= RST_PB;
      pc_data_r <= RST_PC;
      pc_dir_r  <= RST_PC;
      pc_func_r <= RST_PC;
      pb_oe_n_r <= ~RST_PB;
      pc_oe_n_r <= ~RST_PC;
    end else begin
      pb_data_r <= pb_data_nxt;
      pb_dir_r  <= pb_dir_nxt;
      pb_func_r <= pb_func_nxt;
      pc_data_r <= pc_data_nxt;
      pc_dir_r  <= pc_dir_nxt;
      pc_func_r <= pc_func_nxt;
      pb_oe_n_r <= pb_oe_n_nxt;
      pc_oe_n_r <= pc_oe_n_nxt;
    end
  end

  // Register value is read back for outputs and for other functions;
  // a general input shows its synchronised pin, so reads lag the pin by four edges
  for (genvar i = 0; i < PB_W; i++) begin : g_pb_view
    assign pb_regsel[i] = pb_dir_r[i] | pb_func_r[i];
    assign pb_view[i]   = pb_regsel[i] ? pb_data_r[i] : pb_pin[i]; // see [R04] [R05] [R07]
  end

  for (genvar j = 0; j < PC_W; j++) begin : g_pc_view
    assign pc_regsel[j] = pc_dir_r[j] | pc_func_r[j];
    assign pc_view[j]   = pc_regsel[j] ? pc_data_r[j] : pc_pin[j]; // see [R14] [R15] [R17]
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = RST_WORD;
    if (RD) begin
      unique case (ADDR)
        OFS_PB_DATA:   rdata_nxt = {2'h0, pb_view};                  // see [R08]
        OFS_PC_DATA_H: rdata_nxt = {11'h000, pc_view[PC_W-1:PCH_LSB]}; // see [R08] [R12]
        OFS_PC_DATA_L: rdata_nxt = pc_view[PCL_W-1:0];
        OFS_PB_DIR:    rdata_nxt = {2'h0, pb_dir_r};
        OFS_PB_FUNC:   rdata_nxt = {2'h0, pb_func_r};
        OFS_PC_DIR_H:  rdata_nxt = {11'h000, pc_dir_r[PC_W-1:PCH_LSB]};
        OFS_PC_DIR_L:  rdata_nxt = pc_dir_r[PCL_W-1:0];
        OFS_PC_FUNC_H: rdata_nxt = {11'h000, pc_func_r[PC_W-1:PCH_LSB]};
        OFS_PC_FUNC_L: rdata_nxt = pc_func_r[PCL_W-1:0];
        default:       rdata_nxt = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_r <= RST_WORD;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA   = rdata_r;
  assign PB_DOUT = pb_data_r; // see [R02] [R03]
  assign PB_OE_N = pb_oe_n_r;
  assign PC_DOUT = pc_data_r; // see [R11] [R13]
  assign PC_OE_N = pc_oe_n_r;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  sequence pb_read_s;
    RD && (ADDR == OFS_PB_DATA);
  endsequence

  sequence pch_read_s;
    RD && (ADDR == OFS_PC_DATA_H);
  endsequence

  sequence pcl_read_s;
    RD && (ADDR == OFS_PC_DATA_L);
  endsequence

  sequence pb_write_s;
    WR && (ADDR == OFS_PB_DATA);
  endsequence

  sequence pcl_write_s;
    WR && (ADDR == OFS_PC_DATA_L);
  endsequence

  sequence pch_write_s;
    WR && (ADDR == OFS_PC_DATA_H);
  endsequence

  sequence pbdir_write_s;
    WR && (ADDR == OFS_PB_DIR);
  endsequence

  sequence pcldir_write_s;
    WR && (ADDR == OFS_PC_DIR_L);
  endsequence

  // Anything above the last function register is unmapped
  sequence odd_read_s;
    RD && (ADDR > OFS_PC_FUNC_L);
  endsequence

  pb_drive_write_a: assert property (pb_write_s |=> PB_DOUT == $past(WDATA[PB_W-1:0])) // see [R03]
    else $error("port B drive value differs from written data");

  pb_out_read_a: assert property (pb_read_s ##0 (pb_dir_r != '0) |=>
      ((RDATA[PB_W-1:0] ^ $past(pb_data_r)) & $past(pb_dir_r)) == '0) // see [R04]
    else $error("port B register bit read back wrong");

  pb_in_read_a: assert property (pb_read_s |=>
      ((RDATA[PB_W-1:0] ^ $past(pb_pin)) & ~$past(pb_regsel)) == '0) // see [R05]
    else $error("port B input bit does not show pin level");

  pb_enable_map_a: assert property (PB_OE_N == ~(pb_dir_r & ~pb_func_r)) // see [R06] [R07]
    else $error("port B output enable does not follow configuration");

  pb_input_hold_a: assert property (pb_write_s ##0 (pb_dir_r == '0) ##1 (pb_dir_r == '0)
      |-> PB_OE_N == {PB_W{1'b1}}) // see [R06]
    else $error("port B input pin driven after a write");

  resv_zero_a: assert property ((pb_read_s |=> RDATA[15:14] == 2'h0) and
      (pch_read_s |=> RDATA[15:5] == 11'h000)) // see [R08]
    else $error("reserved bits read non-zero");

  pcl_drive_write_a: assert property (pcl_write_s |=> // see [R12] [R13]
      PC_DOUT[PCL_W-1:0] == $past(WDATA) &&
      PC_DOUT[PC_W-1:PCH_LSB] == $past(pc_data_r[PC_W-1:PCH_LSB]))
    else $error("port C low write landed in the wrong pins");

  pch_drive_write_a: assert property (pch_write_s |=> // see [R12] [R13]
      PC_DOUT[PC_W-1:PCH_LSB] == $past(WDATA[PCH_W-1:0]) &&
      PC_DOUT[PCL_W-1:0] == $past(pc_data_r[PCL_W-1:0]))
    else $error("port C high write landed in the wrong pins");

  pc_out_read_a: assert property (pcl_read_s |=>
      ((RDATA ^ $past(pc_data_r[PCL_W-1:0])) & $past(pc_regsel[PCL_W-1:0])) == '0) // see [R14] [R17]
    else $error("port C low register bit read back wrong");

  pc_in_read_a: assert property (pch_read_s |=> // see [R15]
      ((RDATA[PCH_W-1:0] ^ $past(pc_pin[PC_W-1:PCH_LSB])) &
       ~$past(pc_regsel[PC_W-1:PCH_LSB])) == '0)
    else $error("port C input bit does not show pin level");

  pcl_in_read_a: assert property (pcl_read_s |=> // see [R15]
      ((RDATA ^ $past(pc_pin[PCL_W-1:0])) & ~$past(pc_regsel[PCL_W-1:0])) == '0)
    else $error("port C low input bit does not show pin level");

  pch_out_read_a: assert property (pch_read_s |=> // see [R14]
      ((RDATA[PCH_W-1:0] ^ $past(pc_data_r[PC_W-1:PCH_LSB])) &
       $past(pc_regsel[PC_W-1:PCH_LSB])) == '0)
    else $error("port C high register bit read back wrong");

  pb_data_hold_a: assert property (!(WR && (ADDR == OFS_PB_DATA)) |=> $stable(PB_DOUT)) // see [R01]
    else $error("port B data changed without a write");

  pc_data_hold_a: assert property ( // see [R10]
      !(WR && (ADDR == OFS_PC_DATA_H || ADDR == OFS_PC_DATA_L)) |=> $stable(PC_DOUT))
    else $error("port C data changed without a write");

  pb_func_float_a: assert property ((PB_OE_N & pb_func_r) == pb_func_r) // see [R07]
    else $error("port B pin on another function is driven");

  pc_func_float_a: assert property ((PC_OE_N & pc_func_r) == pc_func_r) // see [R17]
    else $error("port C pin on another function is driven");

  pc_input_hold_a: assert property (pcl_write_s ##0 (pc_dir_r[PCL_W-1:0] == '0) ##1 // see [R16]
      (pc_dir_r[PCL_W-1:0] == '0) |-> PC_OE_N[PCL_W-1:0] == {PCL_W{1'b1}})
    else $error("port C input pin driven after a write");

  pb_out_drive_a: assert property (pbdir_write_s |=> // see [R03]
      PB_OE_N == ~($past(WDATA[PB_W-1:0]) & ~pb_func_r))
    else $error("port B output pin not enabled after direction write");

  pc_out_drive_a: assert property (pcldir_write_s |=> // see [R13]
      PC_OE_N[PCL_W-1:0] == ~($past(WDATA) & ~pc_func_r[PCL_W-1:0]))
    else $error("port C output pin not enabled after direction write");

  odd_read_zero_a: assert property (odd_read_s |=> RDATA == '0)
    else $error("unmapped address read non-zero");

  pc_enable_map_a: assert property (PC_OE_N == ~(pc_dir_r & ~pc_func_r)) // see [R16] [R17]
    else $error("port C output enable does not follow configuration");

  rdata_idle_a: assert property (!RD |=> RDATA == '0) // see [R01] [R10]
    else $error("read data present without a read strobe");
endmodule : port_data_bc

// [tb_top.sv]
// Self-checking bench for the port B / port C data register block.
// Assumes the register port and pin ports of port_data_bc; no pad model.
`timescale 1ns/100ps
module tb_top;
  import gpio_bc_pkg::*;
  logic              ref_clk;
  logic              nrst;
  logic              wr;
  logic              rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [PB_W-1:0]   pb_din;
  logic [PB_W-1:0]   pb_dout;
  logic [PB_W-1:0]   pb_oe_n;
  logic [PC_W-1:0]   pc_din;
  logic [PC_W-1:0]   pc_dout;
  logic [PC_W-1:0]   pc_oe_n;
  int                n_fail;
  int                n_compared;
  int                cyc;

  port_data_bc uut (.REF_CLK(ref_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PB_DIN(pb_din), .PB_DOUT(pb_dout), .PB_OE_N(pb_oe_n),
    .PC_DIN(pc_din), .PC_DOUT(pc_dout), .PC_OE_N(pc_oe_n));

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  task automatic tally_and_finish;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // The whole sequence needs about 85 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Entered just after a rising edge; returns just after the edge that took the write
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd   <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(negedge ref_clk);
    chk(32'(rdata), 32'(exp));
    @(posedge ref_clk);
  endtask : rd_reg

  // Pins pass a synchroniser before reads can see them
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  initial begin
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    pb_din = 14'h0000;
    pc_din = 21'h000000;
    idle(8);
    nrst <= 1'b1;
    idle(1);
    rd_reg(OFS_PB_DATA, 16'h0000);
    rd_reg(OFS_PC_DATA_H, 16'h0000);
    rd_reg(OFS_PC_DATA_L, 16'h0000);
    @(negedge ref_clk);
    chk(32'(pb_oe_n), 32'h3fff);
    chk(32'(pc_oe_n), 32'h1fffff);
    @(posedge ref_clk);
    wr_reg(OFS_PB_DIR, 16'h3fff);
    wr_reg(OFS_PB_DATA, 16'h2a5a);
    @(negedge ref_clk);
    chk(32'(pb_dout), 32'h2a5a);
    chk(32'(pb_oe_n), 32'h0000);
    pb_din <= 14'h15a5;
    idle(5);
    rd_reg(OFS_PB_DATA, 16'h2a5a);
    wr_reg(OFS_PB_DIR, 16'h00ff);
    pb_din <= 14'h1234;
    idle(5);
    rd_reg(OFS_PB_DATA, 16'h125a);
    wr_reg(OFS_PB_DATA, 16'h0f0f);
    rd_reg(OFS_PB_DATA, 16'h120f);
    chk(32'(pb_oe_n), 32'h3f00);
    wr_reg(OFS_PB_DIR, 16'h3fff);
    rd_reg(OFS_PB_DATA, 16'h0f0f);
    wr_reg(OFS_PB_FUNC, 16'h0003);
    @(negedge ref_clk);
    chk(32'(pb_oe_n), 32'h0003);
    @(posedge ref_clk);
    wr_reg(OFS_PB_DIR, 16'h0000);
    rd_reg(OFS_PB_DATA, 16'h1237);
    wr_reg(OFS_PC_DIR_H, 16'h001f);
    wr_reg(OFS_PC_DIR_L, 16'hffff);
    wr_reg(OFS_PC_DATA_H, 16'h0015);
    wr_reg(OFS_PC_DATA_L, 16'hc3a5);
    @(negedge ref_clk);
    chk(32'(pc_dout), 32'h15c3a5);
    chk(32'(pc_oe_n), 32'h000000);
    pc_din <= 21'h0a3c5a;
    idle(5);
    rd_reg(OFS_PC_DATA_H, 16'h0015);
    rd_reg(OFS_PC_DATA_L, 16'hc3a5);
    wr_reg(OFS_PC_DIR_H, 16'h0000);
    wr_reg(OFS_PC_DIR_L, 16'h00ff);
    pc_din <= 21'h0abcde;
    idle(5);
    rd_reg(OFS_PC_DATA_H, 16'h000a);
    rd_reg(OFS_PC_DATA_L, 16'hbca5);
    wr_reg(OFS_PC_DATA_H, 16'h0011);
    rd_reg(OFS_PC_DATA_H, 16'h000a);
    chk(32'(pc_oe_n), 32'h1fff00);
    wr_reg(OFS_PC_DIR_H, 16'h001f);
    rd_reg(OFS_PC_DATA_H, 16'h0011);
    wr_reg(OFS_PC_FUNC_H, 16'h0003);
    @(negedge ref_clk);
    chk(32'(pc_oe_n), 32'h03ff00);
    @(posedge ref_clk);
    wr_reg(OFS_PC_DIR_H, 16'h0000);
    rd_reg(OFS_PC_DATA_H, 16'h0009);
    wr_reg(8'h24, 16'hffff);
    rd_reg(8'h24, 16'h0000);
    @(negedge ref_clk);
    chk(32'(rdata), 32'h0000);
    chk(32'(pc_dout), 32'h11c3a5);
    idle(2);
    tally_and_finish();
  end
endmodule : tb_top
